/* File: instrument_state_store.sv */
// Instrument state store: six slots, names, auto-recall, host port
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module instrument_state_store (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   input  wire logic        power_down_i,
   input  wire logic [31:0] live_cfg_i,
   input  wire logic [11:0] mod_type_i,
   output logic      [31:0] cfg_o,
   output logic             cfg_load_o,
   output logic      [2:0]  card_power_on_reset_o,
   output logic             irq_o
);
   localparam int unsigned NS = state_store_pkg::NUM_SLOTS;
   localparam int unsigned MW = state_store_pkg::MTYPE_W;
   localparam int unsigned NW = state_store_pkg::NAME_W;

   typedef struct packed {
      // Slot storage
      logic [NS-1:0][31:0]      cfg;
      logic [NS-1:0][11:0]      mtype;
      logic [NS-1:0]            valid;
      logic [NS-1:0][NW-1:0]    name;
      // Host staging and power sequencing
      logic [NW-1:0]            stage;
      logic                     auto_rcl;
      logic                     booted;
      logic                     pd_done;
      // Configuration handed to the instrument, error code and events
      logic [31:0]              live;
      logic                     load;
      logic [2:0]               card_power_on_reset;
      logic [2:0]               err_code;
      logic [state_store_pkg::EV_W-1:0] ev;
      logic [state_store_pkg::EV_W-1:0] mask;
      // Read path and interrupt
      logic [2:0]               qslot;
      logic [31:0]              rdata;
      logic                     irq;
   } state_s;

   state_s q, d;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic is_letter(input logic [7:0] c);
      return (c >= 8'h41 && c <= 8'h5A) ||
             (c >= 8'h61 && c <= 8'h7A);
   endfunction

   function automatic logic is_tail(input logic [7:0] c);
      return is_letter(c) || (c >= 8'h30 && c <= 8'h39) ||
             c == 8'h5F;
   endfunction

   // Name packed left-justified, char 0 in top byte, 8'h00 terminates
   function automatic logic name_ok(input logic [NW-1:0] n);
      logic ok;
      logic ended;
      ok    = is_letter(n[NW-1 -: 8]);                         // [R11]
      ended = 1'b0;
      for (int i = 1; i < state_store_pkg::NAME_LEN; i++) begin
         if (n[NW-1-8*i -: 8] == 8'h00) begin
            ended = 1'b1;
         end else if (ended || !is_tail(n[NW-1-8*i -: 8])) begin
            ok = 1'b0;                                         // [R11]
         end
      end
      return ok;
   endfunction

   // Per-module type mismatch; slot must hold all module types
   function automatic logic [2:0] type_diff(input logic [11:0] a,
                                            input logic [11:0] b);
      logic [2:0] r;
      for (int m = 0; m < state_store_pkg::NUM_MODS; m++) begin
         r[m] = a[m*MW +: MW] != b[m*MW +: MW];
      end
      return r;
   endfunction

   // Slots past the last one are refused everywhere,
   // never wrapped onto a real slot
   function automatic logic slot_ok(input logic [2:0] s);
      return s < 3'(NS);
   endfunction

   // One 32-bit word of a slot name; an out-of-range query slot
   // reads as an empty name instead of unknown data
   function automatic logic [31:0] name_word(
      input logic [NS-1:0][NW-1:0] names,
      input logic [2:0]            s,
      input logic [1:0]            w
   );
      logic [NW-1:0] one;
      one = '0;
      if (slot_ok(s)) begin
         one = names[s];
      end
      return one[NW-1-32*w -: 32];
   endfunction

   // -----------------------------------------------------------------
   // Next-state logic
   // -----------------------------------------------------------------
   always_comb begin
      logic [2:0]  slot;
      logic [2:0]  diff;
      state_store_pkg::op_e op;
      logic [state_store_pkg::EV_W-1:0] set;
      d    = q;
      slot = wdata_i[state_store_pkg::CMD_SLOT_LSB +: 3];
      op   = state_store_pkg::op_e'(
                wdata_i[state_store_pkg::CMD_OP_LSB +: 3]);
      diff = 3'h0;
      set  = '0;
      // One-cycle pulses fall back each clock
      d.load  = 1'b0;
      d.card_power_on_reset  = 3'h0;
      d.rdata = 32'h0000_0000;

      // ---------------------------------------------------------------
      // Power-up action once out of reset
      // ---------------------------------------------------------------
      if (!q.booted) begin
         d.booted = 1'b1;
         d.load   = 1'b1;
         if (q.auto_rcl && q.valid[0]) begin
            diff   = type_diff(q.mtype[0], mod_type_i);        // [R9]
            d.live = q.cfg[0];                                 // [R15]
            d.card_power_on_reset = diff;                                     // [R9]
         end else begin
            d.live = state_store_pkg::CFG_FACTORY;             // [R15] [R6]
         end
      end else begin
         if (!d.load) begin
            d.live = live_cfg_i;
         end
      end

      // ---------------------------------------------------------------
      // Power-down autosave into slot zero, once per power event
      // ---------------------------------------------------------------
      // Level input; pd_done stops a long power-fail from re-saving
      if (power_down_i && !q.pd_done) begin
         d.cfg[0]   = live_cfg_i;                              // [R2] [R3] [R5]
         d.mtype[0] = mod_type_i;
         d.valid[0] = 1'b1;
         d.pd_done  = 1'b1;
      end else if (!power_down_i) begin
         d.pd_done = 1'b0;
      end

      // ---------------------------------------------------------------
      // Host writes
      // ---------------------------------------------------------------
      // Writes during the power-up edge are dropped on purpose
      if (wr_i && q.booted) begin
         case (addr_i)
            state_store_pkg::A_CMD: begin
               if (!slot_ok(slot)) begin
                  set[state_store_pkg::EV_ERR] = 1'b1;         // [R1]
                  d.err_code = 3'h1;
               end else begin
                  case (op)
                     state_store_pkg::OP_SAVE: begin
                        d.cfg[slot]   = live_cfg_i;            // [R4] [R5]
                        d.mtype[slot] = mod_type_i;
                        d.valid[slot] = 1'b1;                  // [R4]
                        set[state_store_pkg::EV_DONE] = 1'b1;
                     end

                     state_store_pkg::OP_RECALL: begin
                        if (!q.valid[slot]) begin
                           set[state_store_pkg::EV_ERR] = 1'b1; // [R7]
                           d.err_code = 3'h2;
                        end else begin
                           diff   = type_diff(q.mtype[slot], mod_type_i);
                           d.card_power_on_reset = diff;                      // [R9]
                           d.live = q.cfg[slot];               // [R18]
                           d.load = 1'b1;                      // [R18]
                           set[state_store_pkg::EV_DONE] = 1'b1;
                           set[state_store_pkg::EV_CARD_POWER_ON_RESET] = |diff;
                        end
                     end

                     state_store_pkg::OP_DELETE: begin
                        d.valid[slot] = 1'b0;                  // [R14]
                        set[state_store_pkg::EV_DONE] = 1'b1;
                     end

                     state_store_pkg::OP_NAME: begin
                        if (slot == 3'h0 || !name_ok(q.stage)) begin
                           set[state_store_pkg::EV_ERR] = 1'b1; // [R10] [R11]
                           d.err_code = 3'h3;
                        end else begin
                           d.name[slot] = q.stage;
                           set[state_store_pkg::EV_DONE] = 1'b1;
                        end
                     end

                     state_store_pkg::OP_NAME_CLR: begin
                        if (slot == 3'h0) begin
                           set[state_store_pkg::EV_ERR] = 1'b1; // [R10]
                           d.err_code = 3'h3;
                        end else begin
                           d.name[slot] = '0;                  // [R12]
                           set[state_store_pkg::EV_DONE] = 1'b1;
                        end
                     end

                     default: begin
                        set[state_store_pkg::EV_ERR] = 1'b1;
                        d.err_code = 3'h4;
                     end
                  endcase
               end
            end
            state_store_pkg::A_AUTO: begin
               d.auto_rcl = wdata_i[0];                        // [R15]
            end

            state_store_pkg::A_NAME0: begin
               d.stage[NW-1 -: 32] = wdata_i;
            end

            state_store_pkg::A_NAME1: begin
               d.stage[NW-33 -: 32] = wdata_i;
            end

            state_store_pkg::A_NAME2: begin
               d.stage[31:0] = wdata_i;
            end

            state_store_pkg::A_NAMEQ: begin
               d.qslot = wdata_i[2:0];
            end

            state_store_pkg::A_IRQ_ST: begin
               d.ev = q.ev & ~wdata_i[2:0];
            end

            state_store_pkg::A_IRQ_MK: begin
               d.mask = wdata_i[2:0];
            end

            default: begin
            end
         endcase
      end
      // Set wins over a write-one clear in the same cycle
      d.ev = d.ev | set;

      // ---------------------------------------------------------------
      // Host reads
      // ---------------------------------------------------------------
      // Data stand one cycle only; idle cycles read as zero
      if (rd_i) begin
         case (addr_i)
            state_store_pkg::A_STATUS: begin
               d.rdata = {29'h0, q.err_code};
            end

            state_store_pkg::A_AUTO: begin
               d.rdata = {31'h0, q.auto_rcl};                  // [R15]
            end

            state_store_pkg::A_VALID: begin
               d.rdata = {26'h0, q.valid};                     // [R16]
            end

            state_store_pkg::A_COUNT: begin
               d.rdata = {24'h0, state_store_pkg::SLOT_COUNT}; // [R17]
            end

            state_store_pkg::A_NAME0: begin
               d.rdata = name_word(q.name, q.qslot, 2'h0);
            end

            state_store_pkg::A_NAME1: begin
               d.rdata = name_word(q.name, q.qslot, 2'h1);
            end

            state_store_pkg::A_NAME2: begin
               d.rdata = name_word(q.name, q.qslot, 2'h2);     // [R13]
            end

            state_store_pkg::A_NAMEQ: begin
               d.rdata = {29'h0, q.qslot};
            end

            state_store_pkg::A_IRQ_ST: begin
               d.rdata = {29'h0, q.ev};
            end

            state_store_pkg::A_IRQ_MK: begin
               d.rdata = {29'h0, q.mask};
            end

            default: begin
               d.rdata = 32'h0000_0000;
            end
         endcase
      end

      // ---------------------------------------------------------------
      // Interrupt
      // ---------------------------------------------------------------
      d.irq = |(d.ev & d.mask);
   end

   // -----------------------------------------------------------------
   // State register
   // -----------------------------------------------------------------
   // Slot storage stands for the non-volatile array; reset here models
   // the as-shipped contents only.
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q          <= '0;
         q.valid    <= 6'h01;                                  // [R8]
         q.cfg[0]   <= state_store_pkg::CFG_POWERON;           // [R8]
         q.auto_rcl <= state_store_pkg::AUTO_RST;              // [R15]
      end else begin
         q <= d;
      end
   end

   // -----------------------------------------------------------------
   // Outputs, all straight from the state register
   // -----------------------------------------------------------------
   assign rdata_o               = q.rdata;
   assign cfg_o                 = q.live;
   assign cfg_load_o            = q.load;
   assign card_power_on_reset_o = q.card_power_on_reset;
   assign irq_o                 = q.irq;
endmodule // instrument_state_store
`default_nettype wire

/* File: state_store_pkg.sv */
// Constants and types for the instrument state store
// Overview of operation
// R1: Six non-volatile slots, zero to five, each holds a full configuration.
// R2: On power-down the live configuration is written into slot zero.
// R3: Slot zero may hold a saved state but power cycling overwrites it.
// R4: Save overwrites the slot silently and marks it valid.
// R5: A saved state holds every module's complete configuration.
// R6: Factory reset keeps slots; states persist until overwritten or deleted.
// R7: Recall of an empty or deleted slot is refused with an error.
// R8: As shipped, slots one to five empty, slot zero holds power-on state.
// R9: On recall, slots whose module type differs get a card power-on reset.
// R10: Names only for slots one to five; naming slot zero is rejected.
// R11: Name up to 12 chars, letter first, then letters, digits, underscores.
// R12: A name request with no name clears the name, keeps the state.
// R13: Name query returns the name quoted, or an empty quoted string; here unquoted name bytes, an empty name as zeros.
// R14: Delete invalidates slot zero to five contents but keeps its name.
// R15: Auto-recall, default on: power-up recalls slot 0, else factory reset.
// R16: Validity query returns 1 for a stored state, else 0.
// R17: Slot-count query always returns 6.
// R18: Recall applies all settings atomically before the next command.
`default_nettype none
package state_store_pkg;
   // -----------------------------------------------------------------
   // Sizes and reset values
   // -----------------------------------------------------------------
   localparam int unsigned NUM_SLOTS   = 6;
   localparam int unsigned SLOT_W      = 3;
   localparam int unsigned CFG_W       = 32;
   localparam int unsigned NUM_MODS    = 3;
   localparam int unsigned MTYPE_W     = 4;
   localparam int unsigned NAME_LEN    = 12;
   localparam int unsigned NAME_W      = NAME_LEN * 8;
   localparam int unsigned ADDR_W      = 4;
   localparam logic [7:0]  SLOT_COUNT  = 8'h06;
   localparam logic        AUTO_RST    = 1'b1;
   localparam logic [CFG_W-1:0] CFG_FACTORY = 32'h0000_0000;
   localparam logic [CFG_W-1:0] CFG_POWERON = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] A_CMD    = 4'h0;
   localparam logic [ADDR_W-1:0] A_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] A_AUTO   = 4'h2;
   localparam logic [ADDR_W-1:0] A_VALID  = 4'h3;
   localparam logic [ADDR_W-1:0] A_COUNT  = 4'h4;
   localparam logic [ADDR_W-1:0] A_NAME0  = 4'h5;
   localparam logic [ADDR_W-1:0] A_NAME1  = 4'h6;
   localparam logic [ADDR_W-1:0] A_NAME2  = 4'h7;
   localparam logic [ADDR_W-1:0] A_NAMEQ  = 4'h8;
   localparam logic [ADDR_W-1:0] A_IRQ_ST = 4'h9;
   localparam logic [ADDR_W-1:0] A_IRQ_MK = 4'hA;

   // Command register: [2:0] slot, [6:4] opcode
   localparam int unsigned CMD_SLOT_LSB = 0;
   localparam int unsigned CMD_OP_LSB   = 4;

   typedef enum logic [2:0] {
      OP_NOP, OP_SAVE, OP_RECALL, OP_DELETE, OP_NAME, OP_NAME_CLR
   } op_e;

   // Event bits: 0 done, 1 error, 2 card reset issued
   localparam int unsigned EV_DONE = 0;
   localparam int unsigned EV_ERR  = 1;
   localparam int unsigned EV_CARD_POWER_ON_RESET = 2;
   localparam int unsigned EV_W    = 3;
endpackage
`default_nettype wire

/* File: state_store_props.sv */
// Port assertions for the instrument state store
`timescale 1ns/1ps
`default_nettype none
module state_store_props (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        power_down_i,
   input wire logic [31:0] live_cfg_i,
   input wire logic [11:0] mod_type_i,
   input wire logic [31:0] cfg_o,
   input wire logic        cfg_load_o,
   input wire logic [2:0]  card_power_on_reset_o,
   input wire logic        irq_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   logic       cmd_w;
   logic [2:0] op_w;
   assign cmd_w = wr_i && (addr_i == state_store_pkg::A_CMD);
   assign op_w  = wdata_i[6:4];
   a_count_six: assert property (
      rd_i && addr_i == state_store_pkg::A_COUNT |=> rdata_o == 32'h6)
      else $error("slot count wrong");
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data not idle");
   a_bad_slot: assert property (
      cmd_w && op_w == 3'h2 && wdata_i[2:0] > 3'h5 |=> !cfg_load_o)
      else $error("recall of bad slot loaded");
   a_load_cause: assert property (
      cfg_load_o |-> $past(cmd_w && op_w == 3'h2) || !$past(rst_n_i, 2))
      else $error("load without recall");
   a_card_power_on_reset_load: assert property (
      card_power_on_reset_o != 3'h0 |-> cfg_load_o)
      else $error("card reset outside recall");
   a_save_recall: assert property (
      cmd_w && op_w == 3'h1 && wdata_i[2:0] <= 3'h5 ##1 !wr_i ##1
      cmd_w && op_w == 3'h2 && wdata_i[2:0] == $past(wdata_i[2:0], 2)
      |=> cfg_load_o && cfg_o == $past(live_cfg_i, 3))
      else $error("recall differs from save");
   a_valid_save: assert property (
      cmd_w && op_w == 3'h1 && wdata_i[2:0] <= 3'h5 ##1 !wr_i ##1
      rd_i && addr_i == state_store_pkg::A_VALID
      |=> rdata_o[$past(wdata_i[2:0], 3)])
      else $error("saved slot not valid");
   a_delete_valid: assert property (
      cmd_w && op_w == 3'h3 && wdata_i[2:0] <= 3'h5 ##1 !wr_i ##1
      rd_i && addr_i == state_store_pkg::A_VALID
      |=> !rdata_o[$past(wdata_i[2:0], 3)])
      else $error("deleted slot still valid");
endmodule // state_store_props
bind instrument_state_store state_store_props props_u (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .power_down_i(power_down_i),
   .live_cfg_i(live_cfg_i), .mod_type_i(mod_type_i), .cfg_o(cfg_o),
   .cfg_load_o(cfg_load_o), .irq_o(irq_o),
   .card_power_on_reset_o(card_power_on_reset_o));
`default_nettype wire

/* File: host_model.sv */
// Remote host model: single-cycle register writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic        mclk_i,
   input  wire logic [31:0] rdata_i,
   output var  logic [3:0]  addr_o,
   output var  logic [31:0] wdata_o,
   output var  logic        wr_o,
   output var  logic        rd_o
);
   initial begin
      addr_o  = 4'h0;
      wdata_o = 32'h0;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
   end
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr_o  <= a;
      wdata_o <= d;
      wr_o    <= 1'b1;
      @(posedge mclk_i);
      wr_o    <= 1'b0;
      #1;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o   <= 1'b1;
      @(posedge mclk_i);
      rd_o   <= 1'b0;
      #1;
      d = rdata_i;
   endtask
endmodule // host_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking testbench for the instrument state store
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        mclk_i, rst_n_i, wr_i, rd_i, power_down_i, cfg_load_o, irq_o;
   logic [3:0]  addr_i;
   logic [31:0] wdata_i, rdata_o, live_cfg_i, cfg_o;
   logic [11:0] mod_type_i;
   logic [2:0]  card_power_on_reset_o;
   int          err_total, comparisons;
   instrument_state_store dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .power_down_i(power_down_i), .cfg_o(cfg_o),
      .live_cfg_i(live_cfg_i), .mod_type_i(mod_type_i), .irq_o(irq_o),
      .cfg_load_o(cfg_load_o), .card_power_on_reset_o(card_power_on_reset_o));
   host_model host_u (.mclk_i(mclk_i), .rdata_i(rdata_o), .addr_o(addr_i),
      .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
   initial begin
      mclk_i = 1'b0;
      forever #4 mclk_i = ~mclk_i;
   end
   task automatic chk(input logic [31:0] g, e, input string m);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] d;
      host_u.rd_reg(a, d);
      chk(d, e, "read");
   endtask
   task automatic cmd(input logic [2:0] op, s);
      host_u.wr_reg(state_store_pkg::A_CMD, {25'h0, op, 1'b0, s});
   endtask
   task automatic set_live(input logic [31:0] c);
      @(posedge mclk_i);
      live_cfg_i <= c;
   endtask
   // Load pulse stands one cycle, so it is judged right after the command
   task automatic recall(input logic [2:0] s, input logic l,
                         input logic [31:0] c, input logic [2:0] r);
      cmd(3'h2, s);
      chk({31'h0, cfg_load_o}, {31'h0, l}, "load");
      chk({29'h0, card_power_on_reset_o}, {29'h0, r}, "card reset");
      if (l) chk(cfg_o, c, "cfg");
   endtask
   task automatic set_name(input logic [31:0] n0, n1, n2, input logic [2:0] s);
      host_u.wr_reg(state_store_pkg::A_NAME0, n0);
      host_u.wr_reg(state_store_pkg::A_NAME1, n1);
      host_u.wr_reg(state_store_pkg::A_NAME2, n2);
      cmd(3'h4, s);
   endtask
   task automatic t_boot();
      rd_chk(state_store_pkg::A_COUNT, 32'h6);
      rd_chk(state_store_pkg::A_VALID, 32'h1);
      rd_chk(state_store_pkg::A_AUTO, 32'h1);
      host_u.wr_reg(state_store_pkg::A_AUTO, 32'h0);
      rd_chk(state_store_pkg::A_AUTO, 32'h0);
      host_u.wr_reg(state_store_pkg::A_AUTO, 32'h1);
      rd_chk(4'hF, 32'h0);
   endtask
   task automatic t_save_recall();
      set_live(32'hA5A5_1234);
      cmd(3'h1, 3'h3);
      rd_chk(state_store_pkg::A_VALID, 32'h9);
      set_live(32'h1111_2222);
      cmd(3'h1, 3'h3);
      recall(3'h3, 1'b1, 32'h1111_2222, 3'h0);
   endtask
   task automatic t_refuse();
      host_u.wr_reg(state_store_pkg::A_IRQ_ST, 32'h7);
      host_u.wr_reg(state_store_pkg::A_IRQ_MK, 32'h2);
      recall(3'h4, 1'b0, 32'h0, 3'h0);
      rd_chk(state_store_pkg::A_STATUS, 32'h2);
      chk({31'h0, irq_o}, 32'h1, "irq set");
      host_u.wr_reg(state_store_pkg::A_IRQ_ST, 32'h2);
      rd_chk(state_store_pkg::A_IRQ_MK, 32'h2);
      chk({31'h0, irq_o}, 32'h0, "irq clear");
      host_u.wr_reg(state_store_pkg::A_IRQ_MK, 32'h0);
      recall(3'h6, 1'b0, 32'h0, 3'h0);
      rd_chk(state_store_pkg::A_STATUS, 32'h1);
      chk({31'h0, irq_o}, 32'h0, "irq masked");
   endtask
   task automatic t_delete_name();
      set_name(32'h4142_0000, 32'h0, 32'h0, 3'h2);
      cmd(3'h1, 3'h2);
      cmd(3'h3, 3'h2);
      rd_chk(state_store_pkg::A_VALID, 32'h9);
      recall(3'h2, 1'b0, 32'h0, 3'h0);
      host_u.wr_reg(state_store_pkg::A_NAMEQ, 32'h2);
      rd_chk(state_store_pkg::A_NAME0, 32'h4142_0000);
      cmd(3'h5, 3'h2);
      rd_chk(state_store_pkg::A_NAME0, 32'h0);
   endtask
   task automatic t_name_rules();
      cmd(3'h4, 3'h0);
      rd_chk(state_store_pkg::A_STATUS, 32'h3);
      cmd(3'h2, 3'h7);
      set_name(32'h3141_0000, 32'h0, 32'h0, 3'h1);
      rd_chk(state_store_pkg::A_STATUS, 32'h3);
      cmd(3'h2, 3'h7);
      set_name(32'h4120_4200, 32'h0, 32'h0, 3'h1);
      rd_chk(state_store_pkg::A_STATUS, 32'h3);
      set_name(32'h5445_5354, 32'h5F52_4143, 32'h4B5F_3132, 3'h1);
      host_u.wr_reg(state_store_pkg::A_NAMEQ, 32'h1);
      rd_chk(state_store_pkg::A_NAME2, 32'h4B5F_3132);
   endtask
   task automatic t_mismatch_power();
      set_live(32'h0000_CAFE);
      cmd(3'h1, 3'h1);
      @(posedge mclk_i);
      mod_type_i <= 12'h3A1;
      recall(3'h1, 1'b1, 32'h0000_CAFE, 3'h2);
      cmd(3'h1, 3'h0);
      set_live(32'h600D_CAFE);
      @(posedge mclk_i);
      power_down_i <= 1'b1;
      @(posedge mclk_i);
      power_down_i <= 1'b0;
      set_live(32'h0);
      recall(3'h0, 1'b1, 32'h600D_CAFE, 3'h0);
   endtask
   task automatic complete_run();
      $display("errors %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      rst_n_i      = 1'b0;
      power_down_i = 1'b0;
      live_cfg_i   = 32'h0;
      mod_type_i   = 12'h321;
      err_total    = 0;
      comparisons  = 0;
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      t_boot();
      t_save_recall();
      t_refuse();
      t_delete_name();
      t_name_rules();
      t_mismatch_power();
      complete_run();
   end
   // Whole run needs well under 2000 cycles
   initial begin
      #200000;
      err_total++;
      $display("mismatch at %0t: timeout", $time);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
